// File: rtl/flash_status_regs.svh
// Purpose: Shared constants for the flash status query link.
// Assumes: One clock, 250 MHz; bytes move in parallel over the link.
// Notes: Codes, offsets and field positions used by both ends.
`ifndef FLASH_STATUS_REGS_SVH
`define FLASH_STATUS_REGS_SVH
// ----------------------------------------------------------------------
// Link byte values
// ----------------------------------------------------------------------
`define MATCH1_A 8'h86
`define MATCH1_B 8'h30
`define MATCH2_A 8'h79
`define MATCH2_B 8'hcf
`define CMD_STATUS 8'hc3
`define CMD_WRITE 8'h30
`define CMD_READ 8'h37
`define CMD_RAMLOAD 8'h60
`define CMD_ERASE 8'hf0
`define CMD_SUM 8'h90
`define CMD_ID 8'hc0
`define CMD_SECURE 8'hfa
`define START_MARK 8'h3a
`define BYTE_COUNT 8'h04
`define RESERVED_BYTE 8'h00
`define ERR_COMMAND 8'h63
`define ERR_FRAMING 8'ha1
`define ERR_OVERRUN 8'ha3
`define ERR_REPEAT 2'h3
// ----------------------------------------------------------------------
// Status code fields
// ----------------------------------------------------------------------
`define ST_BLANK_BIT 0
`define ST_SECURE_BIT 1
`define ST_DEBUG_BIT 2
`define ST_ERASE_JUDGE_BIT 3
// ----------------------------------------------------------------------
// Controller registers over AHB-Lite (byte addresses)
// ----------------------------------------------------------------------
`define REG_CTRL 8'h00
`define REG_COMMAND 8'h04
`define REG_STATUS 8'h08
`define REG_REPLY 8'h0c
`define REG_LAST_RX 8'h10
`define CTRL_START_BIT 0
`define CTRL_MATCH1_BIT 1
`define CTRL_MATCH2_BIT 2
`define CTRL_RESET 32'h0000_0000
`endif

// File: rtl/flash_status_pkg.sv
// Purpose: Types used by the device end of the status query link.
// Assumes: Nothing beyond the constants header.
// Notes: Holds types only.
package flash_status_pkg;
   // Verdict of the permission matrix on a command.
   typedef enum logic [2:0]
   {
      perm_allow = 3'b001,
      perm_password = 3'b010,
      perm_refuse = 3'b100
   } perm_t;
endpackage : flash_status_pkg

// File: rtl/serial_link_if.sv
// Purpose: Byte link between the programming controller and the device.
// Assumes: Each byte is a one-cycle strobe with data; frame faults ride along.
// Notes: Baud adjustment is modelled by the match bytes alone.
`timescale 1ns/10ps
`default_nettype none
interface serial_link_if;
   logic h2d_valid;
   logic [7:0] h2d_data;
   logic h2d_framing_err;
   logic h2d_overrun_err;
   logic d2h_valid;
   logic [7:0] d2h_data;
   modport controller
   (
      output h2d_valid,
      output h2d_data,
      output h2d_framing_err,
      output h2d_overrun_err,
      input d2h_valid,
      input d2h_data
   );
   modport device
   (
      input h2d_valid,
      input h2d_data,
      input h2d_framing_err,
      input h2d_overrun_err,
      output d2h_valid,
      output d2h_data
   );
endinterface : serial_link_if
`default_nettype wire

// File: rtl/permission_matrix.sv
// Purpose: Decides whether a command may run from the status flags.
// Assumes: Flags are stable while a command is judged.
// Notes: Pure combinational lookup.
`timescale 1ns/10ps
`default_nettype none
`include "flash_status_regs.svh"
module permission_matrix
(
   input wire logic [7:0] command,
   input wire logic secure,
   input wire logic programmed,
   input wire logic erase_judge,
   input wire logic chip_erase,
   output flash_status_pkg::perm_t verdict
);
   // Command classes.
   wire is_wrl = (command == `CMD_WRITE) || (command == `CMD_READ) ||
                 (command == `CMD_RAMLOAD);
   wire is_free = (command == `CMD_STATUS) || (command == `CMD_SUM) ||
                  (command == `CMD_ID);
   wire is_erase = (command == `CMD_ERASE);
   wire is_secure = (command == `CMD_SECURE);

   // Matrix lookup; refusal is the fallback for every unmatched row.
   always_comb
   begin
      verdict = flash_status_pkg::perm_refuse;
      if (is_free)
         verdict = flash_status_pkg::perm_allow; // [R17]
      else if (is_wrl)
      begin
         if (secure)
            verdict = flash_status_pkg::perm_refuse; // [R14]
         else if (programmed)
            verdict = flash_status_pkg::perm_password; // [R17]
         else
            verdict = flash_status_pkg::perm_allow; // [R16]
      end
      else if (is_erase && chip_erase)
      begin
         if (programmed && erase_judge)
            verdict = flash_status_pkg::perm_password; // [R18]
         else
            verdict = flash_status_pkg::perm_allow; // [R16] [R18]
      end
      else if (is_erase)
      begin
         if (programmed && erase_judge && !secure)
            verdict = flash_status_pkg::perm_password; // [R18]
         else
            verdict = flash_status_pkg::perm_refuse; // [R14] [R16]
      end
      else if (is_secure && programmed)
         verdict = flash_status_pkg::perm_password; // [R17]
   end
endmodule : permission_matrix
`default_nettype wire

// File: rtl/status_device.sv
// Purpose: Boot command handler answering the flash status query.
// Assumes: Received bytes arrive as one-cycle strobes, synchronous to hclk.
// Notes: Once idle after an error, only hresetn restarts the handler.
// What this block does
// (R1) First match byte 86 or 30, echoed
// (R2) Second match byte 79 or cf, echoed
// (R3) Command c3 is echoed before reply
// (R4) Command fault sends one code three times
// (R5) Reply starts with 3a then 04
// (R6) Status byte then three zero bytes
// (R7) Last byte is negated sum of four
// (R8) Status byte only 00 to 0f
// (R9) Bit 3 is the erase judgment flag
// (R10) Bit 2 is the debug security flag
// (R11) Bit 1 is security program enabled
// (R12) Bit 0 set if vector area programmed
// (R13) After checksum wait for next command
// (R14) Security refuses write, loader, sector erase
// (R15) Controller chip-erases to regain those commands; here chip_erase_mode only alters the erase verdict
// (R16) Blank device permissions per matrix
// (R17) Programmed device permissions per matrix
// (R18) Erase permissions follow erase judgment
// (R19) Refused command echoed, then idle
// (R20) 63 unknown, a1 framing, a3 overrun
// (R21) Password failure sends nothing
// (R22) Checksum sum kept modulo 256
// (R23) Idle ignores input until reset
//
// Decided for this implementation: the AHB-Lite register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "flash_status_regs.svh"
module status_device
(
   input wire logic hclk,
   input wire logic hresetn,
   serial_link_if.device link,
   input wire logic erase_password_judge_flag,
   input wire logic debug_security_check_flag,
   input wire logic security_program_enabled,
   input wire logic vector_area_programmed,
   input wire logic chip_erase_mode,
   output logic halted,
   output logic [7:0] last_command
);
   typedef enum logic [5:0]
   {
      st_match1 = 6'b000001,
      st_match2 = 6'b000010,
      st_command = 6'b000100,
      st_reply = 6'b001000,
      st_error = 6'b010000,
      st_idle = 6'b100000
   } state_t;

   state_t state;
   logic [2:0] reply_index;
   logic [1:0] err_count;
   logic [7:0] err_code;
   flash_status_pkg::perm_t verdict;

   // ----------------------------------------------------------------------
   // Status byte and checksum
   // ----------------------------------------------------------------------
   function automatic logic [7:0] twos_sum(input logic [7:0] a,
                                           input logic [7:0] b);
      logic [7:0] s;
      s = a + b; // [R22]
      twos_sum = 8'h00 - s; // [R7]
   endfunction : twos_sum

   wire [7:0] status_code = {4'h0, // [R8]
      erase_password_judge_flag, // [R9]
      debug_security_check_flag, // [R10]
      security_program_enabled, // [R11]
      vector_area_programmed}; // [R12]
   wire [7:0] checksum = twos_sum(status_code, `RESERVED_BYTE);

   // Reply table, indexed by position after the echo.
   logic [7:0] reply_byte;
   always_comb
   begin
      case (reply_index)
         3'h0: reply_byte = `START_MARK; // [R5]
         3'h1: reply_byte = `BYTE_COUNT; // [R5]
         3'h2: reply_byte = status_code; // [R6]
         3'h3, 3'h4, 3'h5: reply_byte = `RESERVED_BYTE; // [R6]
         default: reply_byte = checksum; // [R7]
      endcase
   end

   permission_matrix u_matrix
   (
      .command(link.h2d_data),
      .secure(security_program_enabled),
      .programmed(vector_area_programmed),
      .erase_judge(erase_password_judge_flag),
      .chip_erase(chip_erase_mode),
      .verdict(verdict)
   );

   // ----------------------------------------------------------------------
   // Byte classification
   // ----------------------------------------------------------------------
   wire rx = link.h2d_valid;
   wire rx_fault = link.h2d_framing_err || link.h2d_overrun_err;
   wire is_m1 = (link.h2d_data == `MATCH1_A) ||
                (link.h2d_data == `MATCH1_B);
   wire is_m2 = (link.h2d_data == `MATCH2_A) ||
                (link.h2d_data == `MATCH2_B);
   wire is_status = (link.h2d_data == `CMD_STATUS);
   wire [7:0] fault_code = link.h2d_framing_err ? `ERR_FRAMING :
                           link.h2d_overrun_err ? `ERR_OVERRUN :
                           `ERR_COMMAND; // [R20]

   // ----------------------------------------------------------------------
   // Command acceptance
   // ----------------------------------------------------------------------
   // Any defined command is known, whatever the matrix says of it. A
   // refused one is still echoed before the handler falls idle, and only
   // a foreign code earns the command fault. Deciding by the verdict
   // alone would turn every refusal into a fault code, which the far end
   // would read as a broken link rather than a locked device.
   wire known = link.h2d_data inside {`CMD_STATUS, `CMD_WRITE,
      `CMD_READ, `CMD_RAMLOAD, `CMD_ERASE, `CMD_SUM, `CMD_ID,
      `CMD_SECURE}; // [R19] [R20]

   assign halted = (state == st_idle);

   // Main sequencer; one reply byte leaves per cycle.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state <= st_match1;
         reply_index <= 3'h0;
         err_count <= 2'h0;
         err_code <= 8'h00;
         link.d2h_valid <= 1'b0;
         link.d2h_data <= 8'h00;
         last_command <= 8'h00;
      end
      else
      begin
         link.d2h_valid <= 1'b0;
         case (state)
            st_match1:
               if (rx && !rx_fault && is_m1)
               begin
                  link.d2h_valid <= 1'b1; // [R1]
                  link.d2h_data <= link.h2d_data;
                  state <= st_match2;
               end
            st_match2:
               if (rx && !rx_fault && is_m2)
               begin
                  link.d2h_valid <= 1'b1; // [R2]
                  link.d2h_data <= link.h2d_data;
                  state <= st_command;
               end
               else if (rx)
                  state <= st_idle; // [R2]
            st_command:
               if (rx)
               begin
                  last_command <= link.h2d_data;
                  if (rx_fault || !known)
                  begin
                     err_code <= fault_code; // [R4]
                     err_count <= 2'h0;
                     state <= st_error;
                  end
                  else
                  begin
                     link.d2h_valid <= 1'b1; // [R3] [R19]
                     link.d2h_data <= link.h2d_data;
                     reply_index <= 3'h0;
                     // Password checks are not modelled, so any command
                     // other than the query ends here, silently.
                     state <= (is_status &&
                        verdict == flash_status_pkg::perm_allow) ?
                        st_reply : st_idle; // [R19] [R21]
                  end
               end
            st_reply:
            begin
               link.d2h_valid <= 1'b1;
               link.d2h_data <= reply_byte;
               reply_index <= reply_index + 3'h1;
               if (reply_index == 3'h6)
                  state <= st_command; // [R13]
            end
            st_error:
            begin
               link.d2h_valid <= 1'b1;
               link.d2h_data <= err_code; // [R4]
               err_count <= err_count + 2'h1;
               if (err_count == `ERR_REPEAT - 2'h1)
                  state <= st_idle;
            end
            st_idle:
               state <= st_idle; // [R23]
            default:
               state <= st_idle;
         endcase
      end
   end
endmodule : status_device
`default_nettype wire

// File: rtl/status_controller.sv
// Purpose: Programming controller end, driven by software over AHB-Lite.
// Assumes: Single word transfers; slave always answers OKAY, zero wait.
// Notes: Software writes the command, then sets start; reply bytes pile
//        into the reply register, newest in the low byte.
`timescale 1ns/10ps
`default_nettype none
`include "flash_status_regs.svh"
module status_controller
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   serial_link_if.controller link
);
   logic [31:0] ctrl;
   logic [7:0] command;
   logic [31:0] reply;
   logic [7:0] last_rx;
   logic [7:0] rx_count;
   logic [7:0] wr_addr;
   logic wr_pend;

   // ----------------------------------------------------------------------
   // Bus slave
   // ----------------------------------------------------------------------
   wire addr_take = hsel && hready && htrans[1];
   wire [31:0] read_mux =
      (haddr[7:0] == `REG_CTRL) ? ctrl :
      (haddr[7:0] == `REG_COMMAND) ? {24'h0, command} :
      (haddr[7:0] == `REG_STATUS) ? {24'h0, rx_count} :
      (haddr[7:0] == `REG_REPLY) ? reply :
      (haddr[7:0] == `REG_LAST_RX) ? {24'h0, last_rx} : 32'h0;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hrdata <= 32'h0;
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
      end
      else
      begin
         wr_pend <= addr_take && hwrite;
         wr_addr <= haddr[7:0];
         if (addr_take && !hwrite)
            hrdata <= read_mux;
      end
   end

   // Start is a one-shot: it sends the match bytes (only with CTRL_MATCH1_BIT set) and the command in turn.
   wire start_wr = wr_pend && (wr_addr == `REG_CTRL) &&
                   hwdata[`CTRL_START_BIT];
   logic [1:0] send_step;
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ctrl <= `CTRL_RESET;
         command <= `CMD_STATUS;
         send_step <= 2'h0;
         link.h2d_valid <= 1'b0;
         link.h2d_data <= 8'h00;
         link.h2d_framing_err <= 1'b0;
         link.h2d_overrun_err <= 1'b0;
      end
      else
      begin
         link.h2d_valid <= 1'b0;
         if (wr_pend && wr_addr == `REG_COMMAND)
            command <= hwdata[7:0];
         if (wr_pend && wr_addr == `REG_CTRL)
            ctrl <= hwdata;
         if (start_wr)
            send_step <= hwdata[`CTRL_MATCH1_BIT] ? 2'h1 : 2'h3;
         else if (send_step != 2'h0 && !link.d2h_valid)
         begin
            link.h2d_valid <= 1'b1; // [R1] [R2] [R3]
            case (send_step)
               2'h1: link.h2d_data <= ctrl[`CTRL_MATCH2_BIT] ?
                                      `MATCH1_B : `MATCH1_A;
               2'h2: link.h2d_data <= ctrl[`CTRL_MATCH2_BIT] ?
                                      `MATCH2_B : `MATCH2_A;
               default: link.h2d_data <= command;
            endcase
            send_step <= (send_step == 2'h3) ? 2'h0 : send_step + 2'h1;
         end
      end
   end

   // Collect every byte that comes back.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         reply <= 32'h0;
         last_rx <= 8'h00;
         rx_count <= 8'h00;
      end
      else if (link.d2h_valid)
      begin
         reply <= {reply[23:0], link.d2h_data};
         last_rx <= link.d2h_data;
         rx_count <= rx_count + 8'h01;
      end
   end
endmodule : status_controller
`default_nettype wire

// File: testbench/flash_status_checker.sv
// Purpose: Checks what the device sends on the status query link.
// Assumes: One clock; reset asynchronous, active low.
// Notes: Sees the link wires only, so device state is inferred here.
`timescale 1ns/10ps
`default_nettype none
module flash_status_checker
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic h2d_valid,
   input wire logic [7:0] h2d_data,
   input wire logic h2d_framing_err,
   input wire logic h2d_overrun_err,
   input wire logic d2h_valid,
   input wire logic [7:0] d2h_data
);
   default clocking @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   // ----------
   // Inferred state
   // ----------
   logic [1:0] sent;
   logic [1:0] err_cnt;
   // A query echo opens a reply; fault codes close the session.
   wire logic clean = h2d_valid && !h2d_framing_err && !h2d_overrun_err;
   wire logic echo = d2h_valid && d2h_data == 8'hc3;
   wire logic is_err = d2h_valid && d2h_data inside {8'h63, 8'ha1, 8'ha3};
   // Counters saturate, so a long session cannot wrap them back to zero.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         sent <= 2'h0;
         err_cnt <= 2'h0;
      end
      else
      begin
         sent <= sent + {1'b0, d2h_valid && sent != 2'h3};
         err_cnt <= err_cnt + {1'b0, is_err && err_cnt != 2'h3};
      end
   end
   // ----------
   // Assertions
   // ----------
   match1_echo_a: assert property (
      sent == 2'h0 && clean && h2d_data inside {8'h86, 8'h30}
      |=> d2h_valid && d2h_data == $past(h2d_data))
      else $error("first match byte not echoed");
   match2_echo_a: assert property (
      sent + {1'b0, d2h_valid} == 2'h1 && clean &&
      h2d_data inside {8'h79, 8'hcf}
      |=> d2h_valid && d2h_data == $past(h2d_data))
      else $error("second match byte not echoed");
   reply_head_a: assert property (
      echo |=> d2h_valid && d2h_data == 8'h3a
      ##1 d2h_valid && d2h_data == 8'h04)
      else $error("reply head wrong");
   reply_body_a: assert property (
      echo |=> ##2 d2h_valid && d2h_data[7:4] == 4'h0
      ##1 (d2h_valid && d2h_data == 8'h00) [*3])
      else $error("status or reserved byte wrong");
   reply_sum_a: assert property (
      d2h_valid && $past(echo, 7) |-> d2h_data == 8'h00 - $past(d2h_data, 4))
      else $error("checksum wrong");
   reply_span_a: assert property (
      echo |=> d2h_valid [*7] ##1 !d2h_valid)
      else $error("reply length wrong");
   err_triple_a: assert property (
      is_err && err_cnt == 2'h0
      |=> (is_err && $stable(d2h_data)) [*2] ##1 !d2h_valid)
      else $error("fault code not sent three times");
   idle_quiet_a: assert property (
      err_cnt == 2'h3 |-> !d2h_valid)
      else $error("device spoke after a fault");
endmodule : flash_status_checker
`default_nettype wire

// File: testbench/flash_status_output_command_tb.sv
// Purpose: Self-checking bench for the flash status query link.
// Assumes: Software reaches the controller over AHB-Lite.
// Notes: A second device faces a bench driver that injects link faults.
`timescale 1ns/10ps
`default_nettype none
`include "flash_status_regs.svh"
`define CHK(nm, ex, got) \
   begin \
      comparisons++; \
      if ((ex) !== (got)) \
      begin \
         n_errors++; \
         $display("unexpected %s expected %h seen %h", nm, ex, got); \
      end \
   end
module flash_status_output_command_tb;
   // ----------
   // Signals and instances
   // ----------
   logic hclk, hresetn, hsel, hwrite, chip;
   logic [31:0] haddr, hwdata;
   logic [1:0] htrans;
   logic [3:0] flg;
   wire logic [31:0] hrdata;
   wire logic hreadyout, halted, halted2;
   wire logic [7:0] last_cmd;
   int n_errors, comparisons;
   logic [7:0] q1[$], q2[$], ex[$];
   // Refused, password, allowed chip-erase and unknown command table: command, flags {judge, debug, secure, programmed}.
   logic [7:0] c_cmd[10] = '{8'h30, 8'h60, 8'hf0, 8'hfa, 8'h37, 8'hf0,
      8'hf0, 8'hfa, 8'h55, 8'hf0};
   logic [3:0] c_flg[10] = '{4'h2, 4'h2, 4'h0, 4'h0, 4'h1, 4'h9, 4'h1,
      4'h1, 4'h0, 4'h2};
   logic [9:0] c_chip = 10'h220;
   serial_link_if link();
   serial_link_if link2();
   status_controller i_status_controller
   (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(), .link(link)
   );
   status_device i_status_device
   (
      .hclk(hclk), .hresetn(hresetn), .link(link),
      .erase_password_judge_flag(flg[3]), .debug_security_check_flag(flg[2]),
      .security_program_enabled(flg[1]), .vector_area_programmed(flg[0]),
      .chip_erase_mode(chip), .halted(halted), .last_command(last_cmd)
   );
   status_device i_status_device_2
   (
      .hclk(hclk), .hresetn(hresetn), .link(link2),
      .erase_password_judge_flag(flg[3]), .debug_security_check_flag(flg[2]),
      .security_program_enabled(flg[1]), .vector_area_programmed(flg[0]),
      .chip_erase_mode(chip), .halted(halted2), .last_command()
   );
   flash_status_checker i_flash_status_checker
   (
      .hclk(hclk), .hresetn(hresetn), .h2d_valid(link.h2d_valid),
      .h2d_data(link.h2d_data), .h2d_framing_err(link.h2d_framing_err),
      .h2d_overrun_err(link.h2d_overrun_err), .d2h_valid(link.d2h_valid),
      .d2h_data(link.d2h_data)
   );
   // Clock of 4 ns.
   initial
   begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end
   // Every byte a device sends is logged; only one link talks at a time.
   always @(posedge hclk)
   begin
      if (link.d2h_valid === 1'b1)
         q1.push_back(link.d2h_data);
      if (link2.d2h_valid === 1'b1)
         q2.push_back(link2.d2h_data);
   end
   // ----------
   // Tasks
   // ----------
   task final_report();
      $display("mismatches %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : final_report
   // One guarded cycle; a wait that runs too long ends the run.
   task step(inout int k);
      k++;
      if (k > 300)
      begin
         n_errors++;
         final_report();
      end
      else
         @(posedge hclk);
   endtask : step
   task rst();
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      q1.delete();
      q2.delete();
   endtask : rst
   // Single word transfer; address held until hready, then data phase.
   task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r);
      int k;
      k = 0;
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h0, a};
      @(posedge hclk);
      while (hreadyout !== 1'b1)
         step(k);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1)
         step(k);
      r = hrdata;
   endtask : ahb
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      ahb(1'b1, a, d, r);
   endtask : wr
   task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
      logic [31:0] r;
      ahb(1'b0, a, 32'h0, r);
      `CHK(nm, e, r)
   endtask : rd
   // Waits for the expected count, then lingers to catch extra bytes.
   task chk_q();
      int k;
      logic [7:0] got[$];
      k = 0;
      while (q1.size() + q2.size() < ex.size())
         step(k);
      repeat (12) @(posedge hclk);
      got = {q1, q2};
      `CHK("reply length", ex.size(), got.size())
      foreach (ex[i])
         if (i < got.size())
            `CHK("reply byte", ex[i], got[i])
   endtask : chk_q
   // Bench stands in for the controller on the second link.
   task send2(input logic [7:0] b, input logic fe, input logic oe);
      link2.h2d_valid <= 1'b1;
      link2.h2d_data <= b;
      link2.h2d_framing_err <= fe;
      link2.h2d_overrun_err <= oe;
      @(posedge hclk);
      link2.h2d_valid <= 1'b0;
      link2.h2d_data <= ~b;
      link2.h2d_framing_err <= 1'b0;
      link2.h2d_overrun_err <= 1'b0;
      repeat (4) @(posedge hclk);
   endtask : send2
   // ----------
   // Main sequence
   // ----------
   initial
   begin
      logic [7:0] st;
      hresetn = 1'b0;
      hsel = 1'b0;
      hwrite = 1'b0;
      haddr = 32'h0;
      hwdata = 32'h0;
      htrans = 2'h0;
      flg = 4'h0;
      chip = 1'b0;
      link2.h2d_valid = 1'b0;
      link2.h2d_data = 8'h00;
      link2.h2d_framing_err = 1'b0;
      link2.h2d_overrun_err = 1'b0;
      n_errors = 0;
      comparisons = 0;
      rst();
      rd(`REG_CTRL, `CTRL_RESET, "control");
      rd(`REG_COMMAND, 32'h0000_00c3, "command");
      wr(8'h40, 32'h0000_0055);
      rd(`REG_COMMAND, 32'h0000_00c3, "command kept");
      // Every flag pattern, back to back without reset.
      for (int i = 0; i < 16; i++)
      begin
         flg <= i[3:0];
         st = {4'h0, i[3:0]};
         ex.delete();
         if (i == 0)
            ex = {8'h30, 8'hcf};
         ex = {ex, 8'hc3, 8'h3a, 8'h04, st, 8'h00, 8'h00, 8'h00, 8'h00 - st};
         q1.delete();
         wr(`REG_CTRL, (i == 0) ? 32'h7 : 32'h1);
         chk_q();
         rd(`REG_REPLY, {24'h0, 8'h00 - st}, "reply word");
      end
      `CHK("halted", 1'b0, halted)
      rd(`REG_STATUS, 32'h0000_0082, "byte count");
      rd(`REG_LAST_RX, 32'h0000_00f1, "last byte");
      // Refused, password, allowed chip-erase and unknown commands: echo or codes, then idle.
      for (int k = 0; k < 10; k++)
      begin
         rst();
         flg <= c_flg[k];
         chip <= c_chip[k];
         wr(`REG_COMMAND, {24'h0, c_cmd[k]});
         wr(`REG_CTRL, 32'h3);
         ex = {8'h86, 8'h79, c_cmd[k]};
         if (k == 8)
            ex = {8'h86, 8'h79, 8'h63, 8'h63, 8'h63};
         chk_q();
         `CHK("command", c_cmd[k], last_cmd)
         wr(`REG_COMMAND, 32'h0000_00c3);
         wr(`REG_CTRL, 32'h1);
         chk_q();
         `CHK("halted", 1'b1, halted)
      end
      // Faulty bytes and a bad second match byte on the second link.
      for (int j = 0; j < 4; j++)
      begin
         rst();
         send2(8'h55, 1'b0, 1'b0);
         send2(8'h86, 1'b0, 1'b0);
         send2((j < 3) ? 8'h79 : 8'h55, 1'b0, 1'b0);
         send2(8'hc3, j != 1, j != 0);
         send2(8'hc3, 1'b0, 1'b0);
         st = (j == 1) ? 8'ha3 : 8'ha1;
         ex = {8'h86};
         if (j < 3)
            ex = {ex, 8'h79, st, st, st};
         chk_q();
         `CHK("halted", 1'b1, halted2)
      end
      final_report();
   end
endmodule : flash_status_output_command_tb
`default_nettype wire
